// ===== pcc_map.svh
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH
`define PCC_REG_W 40
`define PCC_BYTES 5
`define PCC_RESET_VALUE 40'h00_0078_0000
`define PCC_USED_MASK 40'h83_ffff_ff3f
`define PCC_B_DAC_PD 39
`define PCC_B_BG_PD 33
`define PCC_B_INT_RES 32
`define PCC_F_RISE_HI 31
`define PCC_F_RISE_LO 29
`define PCC_F_FALL_HI 28
`define PCC_F_FALL_LO 26
`define PCC_B_LD_EN 25
`define PCC_B_LD_MODE 24
`define PCC_B_RFDIV_PD 23
`define PCC_F_RFR_HI 22
`define PCC_F_RFR_LO 21
`define PCC_B_DRV_PD 20
`define PCC_F_DSEL_HI 19
`define PCC_F_DSEL_LO 18
`define PCC_B_NO_SURGE 17
`define PCC_B_SYS_BYP 16
`define PCC_F_NDIV_HI 15
`define PCC_F_NDIV_LO 12
`define PCC_F_MDIV_HI 11
`define PCC_F_MDIV_LO 8
`define PCC_B_CP_POL 5
`define PCC_B_CP_PD 4
`define PCC_B_CP_QPD 3
`define PCC_F_CPI_HI 2
`define PCC_F_CPI_LO 0
`define PCC_BG_SETTLE_MS 10
`define PCC_CLK_MHZ 125
`endif

// ===== pcc_pkg.sv
`default_nettype none
package pcc_pkg;
    typedef enum logic [1:0] {
        PCC_DRV_OFF = 2'b00,
        PCC_DRV_FB = 2'b01,
        PCC_DRV_RFOUT = 2'b10,
        PCC_DRV_RFIN = 2'b11
    } pcc_drv_src_t;
    typedef enum logic [1:0] {
        PCC_ST_IDLE = 2'b00,
        PCC_ST_SHIFT = 2'b01,
        PCC_ST_DONE = 2'b10
    } pcc_wr_state_t;
endpackage : pcc_pkg
`default_nettype wire

// ===== pcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule : pcc_sync
`default_nettype wire

// ===== pcc_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_settle_timer #(
    parameter int CYCLES = 1
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic start_i,
    output logic busy_o
);
    logic [31:0] count;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            count <= 32'h0000_0000;
        end else if (start_i) begin
            count <= 32'(CYCLES);
        end else if (count != 32'h0000_0000) begin
            count <= count - 32'h0000_0001;
        end
    end
    assign busy_o = (count != 32'h0000_0000);
endmodule : pcc_settle_timer
`default_nettype wire

// ===== pcc_top.sv
// Summary of operation
// - Bit 39 high powers down DAC, output goes high impedance.
// - Bit 33 powers down band gap; about 10 ms settling after power-up.
// - Bit 32 selects internal driver current resistor instead of pin.
// - Bits 31:29 add rising surge current 7.6, 3.8, 1.9 mA.
// - Bits 28:26 add falling surge current 5.4, 2.7, 1.35 mA.
// - Bit 25 makes the shared status pin a lock-detect output.
// - Bit 24 low: status shows 0 locked, 1 unlocked.
// - Bit 24 high: status 1 when feedback lags reference, else 0.
// - Bit 23 powers down RF divider and enables bypass path.
// - Bits 22:21 select RF divide by 1, 2, 4 or 8.
// - Bit 20 default high keeps output driver off; low powers it.
// - Bits 19:18 pick driver source: off, feedback, divider out, in.
// - Bit 17 removes all surge current including defaults.
// - Bit 16 picks system clock from divider output or input.
// - Feedback divider ratio is bits 15:12 plus one.
// - Reference divider ratio is bits 11:8 plus one.
// - Bit 5 sets charge pump polarity for lagging feedback clock.
// - Bit 4 fully powers down the charge pump.
// - Bit 3 powers down only the charge pump output buffer.
// - Pump current multiplier is bits 2:0 plus one.
`timescale 1ns/1ps
`include "pcc_map.svh"
`default_nettype none
module pcc_top #(
    parameter int BG_SETTLE_CYCLES = `PCC_BG_SETTLE_MS * `PCC_CLK_MHZ * 1000
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic sel_n_i,
    input wire logic pll_unlocked_i,
    input wire logic fb_lags_ref_i,
    output logic [`PCC_REG_W-1:0] readback_o,
    output logic write_done_o,
    output logic dac_pd_o,
    output logic dac_out_hiz_o,
    output logic bg_pd_o,
    output logic bg_settling_o,
    output logic drv_int_res_o,
    output logic [2:0] rise_surge_o,
    output logic [2:0] fall_surge_o,
    output logic default_surge_o,
    output logic status_o,
    output logic status_oe_n_o,
    output logic rfdiv_pd_o,
    output logic rf_bypass_path_o,
    output logic [3:0] rf_ratio_o,
    output logic drv_pd_o,
    output pcc_pkg::pcc_drv_src_t drv_src_o,
    output logic sys_from_rfin_o,
    output logic [4:0] fb_ratio_o,
    output logic [4:0] ref_ratio_o,
    output logic cp_invert_o,
    output logic cp_pd_o,
    output logic cp_out_pd_o,
    output logic [3:0] cp_mult_o
);
    logic [`PCC_REG_W-1:0] ctrl;
    logic [`PCC_REG_W-1:0] shreg;
    logic [5:0] bitcnt;
    pcc_pkg::pcc_wr_state_t state;
    logic sclk_s;
    logic sdata_s;
    logic sel_n_s;
    logic unlocked_s;
    logic lags_s;
    logic sclk_d;
    logic bg_prev;
    logic bg_busy;
    wire sclk_rise = sclk_s && !sclk_d;
    wire last_bit = (bitcnt == 6'(`PCC_REG_W - 1));
    wire [`PCC_REG_W-1:0] next_shreg = {shreg[`PCC_REG_W-2:0], sdata_s};
    wire commit = (state == pcc_pkg::PCC_ST_SHIFT) && sclk_rise && !sel_n_s && last_bit;
    wire bg_powerup = bg_prev && !ctrl[`PCC_B_BG_PD];
    wire [2:0] rfr = {1'b0, ctrl[`PCC_F_RFR_HI:`PCC_F_RFR_LO]};
    wire next_status = ctrl[`PCC_B_LD_MODE] ? lags_s : unlocked_s;

    pcc_sync #(.WIDTH(5)) u_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .async_i({sclk_i, sdata_i, sel_n_i, pll_unlocked_i, fb_lags_ref_i}),
        .sync_o({sclk_s, sdata_s, sel_n_s, unlocked_s, lags_s})
    );

    pcc_settle_timer #(.CYCLES(BG_SETTLE_CYCLES)) u_bg_timer (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .start_i(bg_powerup),
        .busy_o(bg_busy)
    );

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sclk_d <= 1'b0;
            bg_prev <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            bg_prev <= ctrl[`PCC_B_BG_PD];
        end
    end

    // Serial write: only a full 40-bit frame updates the register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state <= pcc_pkg::PCC_ST_IDLE;
            bitcnt <= 6'h00;
            shreg <= '0;
        end else begin
            unique case (state)
                pcc_pkg::PCC_ST_IDLE: begin
                    bitcnt <= 6'h00;
                    if (!sel_n_s) begin
                        state <= pcc_pkg::PCC_ST_SHIFT;
                    end
                end
                pcc_pkg::PCC_ST_SHIFT: begin
                    if (sel_n_s) begin
                        state <= pcc_pkg::PCC_ST_IDLE;
                    end else if (sclk_rise) begin
                        shreg <= next_shreg;
                        bitcnt <= bitcnt + 6'h01;
                        if (last_bit) begin
                            state <= pcc_pkg::PCC_ST_DONE;
                        end
                    end
                end
                pcc_pkg::PCC_ST_DONE: begin
                    if (sel_n_s) begin
                        state <= pcc_pkg::PCC_ST_IDLE;
                    end
                end
                default: begin
                    state <= pcc_pkg::PCC_ST_IDLE;
                end
            endcase
        end
    end

    // Control register; unused bits forced to zero
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl <= `PCC_RESET_VALUE;
            write_done_o <= 1'b0;
        end else begin
            write_done_o <= commit;
            if (commit) begin
                ctrl <= next_shreg & `PCC_USED_MASK;
            end
        end
    end

    // Decoded outputs, all registered
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            readback_o <= `PCC_RESET_VALUE;
            dac_pd_o <= 1'b0;
            dac_out_hiz_o <= 1'b0;
            bg_pd_o <= 1'b0;
            bg_settling_o <= 1'b0;
            drv_int_res_o <= 1'b0;
            rise_surge_o <= 3'h0;
            fall_surge_o <= 3'h0;
            default_surge_o <= 1'b1;
            status_o <= 1'b0;
            status_oe_n_o <= 1'b1;
            rfdiv_pd_o <= 1'b0;
            rf_bypass_path_o <= 1'b0;
            rf_ratio_o <= 4'h8;
            drv_pd_o <= 1'b1;
            drv_src_o <= pcc_pkg::PCC_DRV_RFOUT;
            sys_from_rfin_o <= 1'b0;
            fb_ratio_o <= 5'h01;
            ref_ratio_o <= 5'h01;
            cp_invert_o <= 1'b0;
            cp_pd_o <= 1'b0;
            cp_out_pd_o <= 1'b0;
            cp_mult_o <= 4'h1;
        end else begin
            readback_o <= ctrl;
            dac_pd_o <= ctrl[`PCC_B_DAC_PD];
            dac_out_hiz_o <= ctrl[`PCC_B_DAC_PD];
            bg_pd_o <= ctrl[`PCC_B_BG_PD];
            bg_settling_o <= bg_busy;
            drv_int_res_o <= ctrl[`PCC_B_INT_RES];
            rise_surge_o <= ctrl[`PCC_B_NO_SURGE] ? 3'h0 : ctrl[`PCC_F_RISE_HI:`PCC_F_RISE_LO];
            fall_surge_o <= ctrl[`PCC_B_NO_SURGE] ? 3'h0 : ctrl[`PCC_F_FALL_HI:`PCC_F_FALL_LO];
            default_surge_o <= !ctrl[`PCC_B_NO_SURGE];
            status_o <= ctrl[`PCC_B_LD_EN] ? next_status : 1'b0;
            status_oe_n_o <= !ctrl[`PCC_B_LD_EN];
            rfdiv_pd_o <= ctrl[`PCC_B_RFDIV_PD];
            rf_bypass_path_o <= ctrl[`PCC_B_RFDIV_PD];
            rf_ratio_o <= 4'h1 << rfr;
            drv_pd_o <= ctrl[`PCC_B_DRV_PD];
            drv_src_o <= pcc_pkg::pcc_drv_src_t'(ctrl[`PCC_F_DSEL_HI:`PCC_F_DSEL_LO]);
            sys_from_rfin_o <= ctrl[`PCC_B_SYS_BYP];
            fb_ratio_o <= {1'b0, ctrl[`PCC_F_NDIV_HI:`PCC_F_NDIV_LO]} + 5'h01;
            ref_ratio_o <= {1'b0, ctrl[`PCC_F_MDIV_HI:`PCC_F_MDIV_LO]} + 5'h01;
            cp_invert_o <= ctrl[`PCC_B_CP_POL];
            cp_pd_o <= ctrl[`PCC_B_CP_PD];
            cp_out_pd_o <= ctrl[`PCC_B_CP_QPD] | ctrl[`PCC_B_CP_PD];
            cp_mult_o <= {1'b0, ctrl[`PCC_F_CPI_HI:`PCC_F_CPI_LO]} + 4'h1;
        end
    end
endmodule : pcc_top
`default_nettype wire

// ===== pcc_checker.sv
`timescale 1ns/1ps
`include "pcc_map.svh"
`default_nettype none
module pcc_checker (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [`PCC_REG_W-1:0] readback_o,
    input wire logic dac_pd_o,
    input wire logic dac_out_hiz_o,
    input wire logic bg_pd_o,
    input wire logic bg_settling_o,
    input wire logic [2:0] rise_surge_o,
    input wire logic [2:0] fall_surge_o,
    input wire logic default_surge_o,
    input wire logic status_oe_n_o,
    input wire logic rfdiv_pd_o,
    input wire logic rf_bypass_path_o,
    input wire logic [3:0] rf_ratio_o,
    input wire logic drv_pd_o,
    input wire pcc_pkg::pcc_drv_src_t drv_src_o,
    input wire logic [4:0] fb_ratio_o,
    input wire logic [4:0] ref_ratio_o,
    input wire logic [3:0] cp_mult_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    wire [39:0] rb = readback_o;
    property p_dac; dac_pd_o == rb[39] && dac_out_hiz_o == rb[39]; endproperty
    a_dac: assert property (p_dac) else $error("dac power-down wrong");
    property p_srg; default_surge_o == !rb[17] && rise_surge_o == (rb[17] ? 3'h0 : rb[31:29])
        && fall_surge_o == (rb[17] ? 3'h0 : rb[28:26]); endproperty
    a_srg: assert property (p_srg) else $error("surge select wrong");
    property p_ld; status_oe_n_o == !rb[25]; endproperty
    a_ld: assert property (p_ld) else $error("status enable wrong");
    property p_rf; rf_ratio_o == (4'h1 << rb[22:21]) && rfdiv_pd_o == rb[23] && rf_bypass_path_o == rb[23]; endproperty
    a_rf: assert property (p_rf) else $error("rf divider wrong");
    property p_fb; fb_ratio_o == 5'h01 + rb[15:12]; endproperty
    a_fb: assert property (p_fb) else $error("feedback ratio wrong");
    property p_ref; ref_ratio_o == 5'h01 + rb[11:8]; endproperty
    a_ref: assert property (p_ref) else $error("reference ratio wrong");
    property p_cp; cp_mult_o == 4'h1 + rb[2:0]; endproperty
    a_cp: assert property (p_cp) else $error("pump scale wrong");
    property p_drv; drv_pd_o == rb[20] && drv_src_o == rb[19:18]; endproperty
    a_drv: assert property (p_drv) else $error("driver control wrong");
    property p_rst; $fell(reset_i) |-> readback_o == `PCC_RESET_VALUE; endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    sequence s_bg_on; $fell(bg_pd_o); endsequence
    property p_bg; s_bg_on |-> ##[0:3] bg_settling_o; endproperty
    a_bg: assert property (p_bg) else $error("no band gap settling");
endmodule : pcc_checker
bind pcc_top pcc_checker u_chk (.*);
`default_nettype wire

// ===== pcc_top_bench.sv
`timescale 1ns/1ps
`include "pcc_map.svh"
`default_nettype none
module pcc_top_bench;
    logic mclk_i, reset_i, sclk_i, sdata_i, sel_n_i, pll_unlocked_i, fb_lags_ref_i;
    logic [39:0] readback_o;
    logic write_done_o, dac_pd_o, dac_out_hiz_o, bg_pd_o, bg_settling_o, drv_int_res_o, default_surge_o;
    logic status_o, status_oe_n_o, rfdiv_pd_o, rf_bypass_path_o, drv_pd_o, sys_from_rfin_o;
    logic cp_invert_o, cp_pd_o, cp_out_pd_o;
    logic [2:0] rise_surge_o, fall_surge_o;
    logic [3:0] rf_ratio_o, cp_mult_o;
    logic [4:0] fb_ratio_o, ref_ratio_o;
    pcc_pkg::pcc_drv_src_t drv_src_o;
    int num_errors = 0;
    int checks_done = 0;
    pcc_top #(.BG_SETTLE_CYCLES(20)) u_dut (.*);
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [39:0] v, input int nb);
        int n;
        v = v & `PCC_USED_MASK;
        sel_n_i = 1'b0;
        for (int i = 39; i >= 40 - nb; i--) begin
            sclk_i = 1'b0;
            sdata_i = v[i];
            repeat (4) @(negedge mclk_i);
            sclk_i = 1'b1;
            if (i > 40 - nb) repeat (4) @(negedge mclk_i);
        end
        n = 0;
        while (write_done_o !== 1'b1 && n < 12) begin
            @(negedge mclk_i);
            n++;
        end
        chk(n < 12, nb == 40);
        sel_n_i = 1'b1;
        sclk_i = 1'b0;
        repeat (4) @(negedge mclk_i);
    endtask : wr
    task automatic t_reset;
        reset_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        reset_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk(readback_o, `PCC_RESET_VALUE);
        chk({drv_pd_o, drv_src_o, rf_ratio_o, fb_ratio_o, cp_mult_o, bg_pd_o}, {1'b1, 2'h2, 4'h8, 5'h01, 4'h1, 1'b0});
    endtask : t_reset
    task automatic t_fields(input logic [39:0] v);
        wr(v, 40);
        chk(readback_o, v);
        chk({dac_pd_o, dac_out_hiz_o, bg_pd_o, drv_int_res_o}, {v[39], v[39], v[33], v[32]});
        chk({rfdiv_pd_o, rf_bypass_path_o, drv_pd_o, sys_from_rfin_o}, {v[23], v[23], v[20], v[16]});
        chk({cp_invert_o, cp_pd_o, cp_out_pd_o}, {v[5], v[4], v[4] | v[3]});
        chk({default_surge_o, rise_surge_o, fall_surge_o}, {!v[17], v[31:26] & {6{!v[17]}}});
        chk(rf_ratio_o, 4'h1 << v[22:21]);
        chk(drv_src_o, v[19:18]);
        chk({fb_ratio_o, ref_ratio_o, cp_mult_o}, {5'h01 + v[15:12], 5'h01 + v[11:8], 4'h1 + v[2:0]});
        for (int k = 0; k < 2; k++) begin
            pll_unlocked_i = !k[0];
            fb_lags_ref_i = k[0];
            repeat (5) @(negedge mclk_i);
            chk(status_oe_n_o, !v[25]);
            chk(status_o, v[25] & (v[24] ? k[0] : !k[0]));
        end
    endtask : t_fields
    task automatic t_short;
        wr(40'h00_0000_0000, 16);
        chk(readback_o, 40'h82_5a55_a71c);
    endtask : t_short
    task automatic t_bg;
        wr(40'h00_0000_0000, 40);
        chk(bg_settling_o, 1'b1);
        repeat (25) @(negedge mclk_i);
        chk(bg_settling_o, 1'b0);
    endtask : t_bg
    task automatic print_verdict;
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        reset_i = 1'b1;
        sclk_i = 1'b0;
        sdata_i = 1'b0;
        sel_n_i = 1'b1;
        pll_unlocked_i = 1'b0;
        fb_lags_ref_i = 1'b0;
        t_reset();
        t_fields(40'h00_0000_0000);
        t_fields(40'h83_ffff_ff3f);
        t_fields(40'h01_a52a_5a25);
        t_fields(40'h82_5a55_a71c);
        t_short();
        t_bg();
        t_reset();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        print_verdict();
    end
endmodule : pcc_top_bench
`default_nettype wire
